/* File: rtl/fps_pkg.sv */
// Constants, register map and command codes for the flash sequencer.
// Assumes a 100 MHz system clock and a 16-bit register port.
// Notes on behaviour
// - Start bit launches timed operation, self-clears
// - Enable bit clear inhibits every operation
// - Error flag set on bad sequence or abort
// - Erase-select bit chooses erase or program
// - Codes erase four, two or one rows
// - Config, EEPROM and general bulk erases
// - Boot and full erases only in serial mode
// - Row write programs one row from latches
// - Undefined operation codes do nothing
// - Row target taken from last table write
// - Skip-preerase bit affects EEPROM only
// - Key 55h then AAh must precede start
// - Core stalled during program-memory cycle
// - Control bits eleven to seven read zero
// - Table writes fill latches, later overwrite earlier
// - Key register is write-only
package fps_pkg;
    // Register indices on the plain register port
    localparam logic [3:0]  FPS_OFS_CTRL     = 4'h0;
    localparam logic [3:0]  FPS_OFS_KEY      = 4'h2;
    localparam logic [3:0]  FPS_OFS_PAGE     = 4'h4;
    // Control register fields
    localparam int          FPS_BIT_START    = 15;
    localparam int          FPS_BIT_EN       = 14;
    localparam int          FPS_BIT_ERR      = 13;
    localparam int          FPS_BIT_SKIP     = 12;
    localparam int          FPS_BIT_ERASE    = 6;
    localparam logic [15:0] FPS_CTRL_RESET   = 16'h0000;
    localparam logic [7:0]  FPS_KEY_FIRST    = 8'h55;
    localparam logic [7:0]  FPS_KEY_SECOND   = 8'haa;
    // Operation field codes
    localparam logic [5:0]  FPS_OP_ERASE4    = 6'h1a;
    localparam logic [5:0]  FPS_OP_ERASE2    = 6'h19;
    localparam logic [5:0]  FPS_OP_ERASE1    = 6'h18;
    localparam logic [3:0]  FPS_OPH_BOOT     = 4'ha;
    localparam logic [3:0]  FPS_OPH_ALL      = 4'h9;
    localparam logic [3:0]  FPS_OPH_CFG      = 4'h5;
    localparam logic [3:0]  FPS_OPH_EE       = 4'h4;
    localparam logic [3:0]  FPS_OPH_GEN      = 4'h3;
    localparam logic [3:0]  FPS_OPH_WRITE    = 4'h1;
    // Address layout: page above a 16-bit offset, 32 instructions per row
    localparam int          FPS_ADDR_W       = 24;
    localparam int          FPS_ROW_WORDS    = 32;
    localparam int          FPS_IDX_W        = 5;
    localparam logic [23:0] FPS_EE_BASE      = 24'h7ffe00;
    localparam logic [23:0] FPS_MASK_1ROW    = 24'hffffc0;
    localparam logic [23:0] FPS_MASK_2ROW    = 24'hffff80;
    localparam logic [23:0] FPS_MASK_4ROW    = 24'hffff00;
    // Self-timed durations in microseconds
    localparam int          FPS_CLK_MHZ      = 100;
    localparam int          FPS_ERASE_US     = 2000;
    localparam int          FPS_WRITE_US     = 2000;
    localparam int          FPS_ERASE_CYC    = FPS_ERASE_US * FPS_CLK_MHZ;
    localparam int          FPS_WRITE_CYC    = FPS_WRITE_US * FPS_CLK_MHZ;
    localparam int          FPS_CNT_W        = 20;
    // Command presented to the array
    typedef enum logic [3:0] {
        FPS_CMD_NONE   = 4'h0,
        FPS_CMD_ERASE1 = 4'h1,
        FPS_CMD_ERASE2 = 4'h2,
        FPS_CMD_ERASE4 = 4'h3,
        FPS_CMD_CFG    = 4'h4,
        FPS_CMD_EE     = 4'h5,
        FPS_CMD_GEN    = 4'h6,
        FPS_CMD_BOOT   = 4'h7,
        FPS_CMD_ALL    = 4'h8,
        FPS_CMD_WRITE  = 4'h9,
        FPS_CMD_EEWR   = 4'ha
    } fps_cmd_t;
endpackage : fps_pkg

/* File: rtl/fps_latch_if.sv */
// Carrier between the sequencer and its holding-latch memory.
// Assumes one clock; write lanes are the low word and the high byte.
`timescale 1ns/1ps
`default_nettype none
interface fps_latch_if;
    import fps_pkg::*;
    logic                 wr_lo;
    logic                 wr_hi;
    logic [FPS_IDX_W-1:0] wr_idx;
    logic [15:0]          wr_data;
    logic [FPS_IDX_W-1:0] rd_idx;
    logic [23:0]          rd_data;
    modport ctrl (output wr_lo, output wr_hi, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport mem  (input wr_lo, input wr_hi, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface : fps_latch_if
`default_nettype wire

/* File: rtl/fps_latch_mem.sv */
// Row of holding latches filled by table writes.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/1ps
`default_nettype none
module fps_latch_mem #(
    parameter int WORDS = 32
) (
    input  wire logic clk,
    fps_latch_if.mem  lif
);
    import fps_pkg::*;
    logic [23:0] lat_r [WORDS];
    logic [23:0] rd_data_r;

    // Lanes written separately; a later write simply replaces the old value
    always_ff @(posedge clk)
    begin
        if (lif.wr_lo)
            lat_r[lif.wr_idx][15:0] <= lif.wr_data;
        if (lif.wr_hi)
            lat_r[lif.wr_idx][23:16] <= lif.wr_data[7:0];
    end

    // Registered read port
    always_ff @(posedge clk)
    begin
        rd_data_r <= lat_r[lif.rd_idx];
    end

    assign lif.rd_data = rd_data_r;
endmodule : fps_latch_mem
`default_nettype wire

/* File: rtl/fps_sequencer.sv */
// Program/erase sequencer: control, key and page registers, holding
// latches, command decode, self-timed cycle and core stall.
// Assumes register port and table writes synchronous to clk; the array
// takes arr_start as a one-cycle command and reads latches by index.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer
    import fps_pkg::*;
#(
    parameter int ERASE_CYCLES = FPS_ERASE_CYC,
    parameter int WRITE_CYCLES = FPS_WRITE_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic [3:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [15:0]                   reg_rdata,
    input  wire logic                     tbl_wr,
    input  wire logic                     tbl_hi,
    input  wire logic [15:0]              tbl_offset,
    input  wire logic [15:0]              tbl_data,
    input  wire logic                     serial_mode,
    input  wire logic                     abort_req,
    input  wire logic [fps_pkg::FPS_IDX_W-1:0] arr_rd_idx,
    output logic [23:0]                   arr_rd_data,
    output logic                          arr_start,
    output fps_pkg::fps_cmd_t             arr_cmd,
    output logic [fps_pkg::FPS_ADDR_W-1:0] arr_addr,
    output logic                          arr_abort,
    output logic                          cpu_stall
);
    import fps_pkg::*;

    typedef enum logic [1:0] {
        FPS_ST_IDLE = 2'b01,
        FPS_ST_RUN  = 2'b10
    } fps_state_t;

    fps_state_t            state_r;
    logic                  start_r;
    logic                  en_r;
    logic                  err_r;
    logic                  skip_r;
    logic                  erase_r;
    logic [5:0]            op_r;
    logic [7:0]            page_r;
    logic                  key1_r;
    logic                  unlock_r;
    logic [FPS_ADDR_W-1:0] tgt_r;
    logic [FPS_CNT_W-1:0]  cnt_r;
    logic                  arr_start_r;
    fps_cmd_t              arr_cmd_r;
    logic [FPS_ADDR_W-1:0] arr_addr_r;
    logic                  arr_abort_r;
    logic                  stall_r;
    logic [15:0]           rdata_r;

    logic                  wr_ctrl;
    logic                  wr_key;
    logic                  wr_page;
    logic                  launch;
    logic                  refuse;
    logic                  done;
    fps_cmd_t              cmd_nxt;
    logic                  is_ee;
    logic [FPS_CNT_W-1:0]  dur_nxt;
    logic [FPS_ADDR_W-1:0] addr_nxt;

    fps_latch_if lif ();

    fps_latch_mem #(
        .WORDS (FPS_ROW_WORDS)
    ) u_latch (
        .clk (clk),
        .lif (lif)
    );

    // Map operation field and mode to an array command
    function automatic fps_cmd_t decode_op(input logic erase, input logic [5:0] op,
                                           input logic serial, input logic ee);
        fps_cmd_t c;
        c = FPS_CMD_NONE;
        if (erase)
        begin
            if (op == FPS_OP_ERASE4)
                c = FPS_CMD_ERASE4;
            else if (op == FPS_OP_ERASE2)
                c = FPS_CMD_ERASE2;
            else if (op == FPS_OP_ERASE1)
                c = FPS_CMD_ERASE1;
            else if (op[5:2] == FPS_OPH_CFG)
                c = FPS_CMD_CFG;
            else if (op[5:2] == FPS_OPH_EE)
                c = FPS_CMD_EE;
            else if (op[5:2] == FPS_OPH_GEN)
                c = FPS_CMD_GEN;
            else if (op[5:2] == FPS_OPH_BOOT && serial)
                c = FPS_CMD_BOOT;
            else if (op[5:2] == FPS_OPH_ALL && serial)
                c = FPS_CMD_ALL;
        end
        else if (op[5:2] == FPS_OPH_WRITE)
            c = ee ? FPS_CMD_EEWR : FPS_CMD_WRITE;
        return c;
    endfunction : decode_op

    // Row-aligned start address for the chosen block size
    function automatic logic [FPS_ADDR_W-1:0] align_addr(input fps_cmd_t c,
                                                         input logic [FPS_ADDR_W-1:0] a);
        logic [FPS_ADDR_W-1:0] r;
        r = a;
        unique case (c)
            FPS_CMD_ERASE2: r = a & FPS_MASK_2ROW;
            FPS_CMD_ERASE4: r = a & FPS_MASK_4ROW;
            FPS_CMD_ERASE1,
            FPS_CMD_WRITE:  r = a & FPS_MASK_1ROW;
            default:        r = a;
        endcase
        return r;
    endfunction : align_addr

    // Bus decode
    assign wr_ctrl = reg_wr && (reg_addr == FPS_OFS_CTRL);
    assign wr_key  = reg_wr && (reg_addr == FPS_OFS_KEY);
    assign wr_page = reg_wr && (reg_addr == FPS_OFS_PAGE);

    // Start attempt: accepted only when unlocked and enabled
    assign is_ee   = (tgt_r >= FPS_EE_BASE);
    assign launch  = wr_ctrl && reg_wdata[FPS_BIT_START] && state_r == FPS_ST_IDLE
                     && unlock_r && reg_wdata[FPS_BIT_EN];
    assign refuse  = wr_ctrl && reg_wdata[FPS_BIT_START] && state_r == FPS_ST_IDLE
                     && !(unlock_r && reg_wdata[FPS_BIT_EN]);
    assign cmd_nxt = decode_op(reg_wdata[FPS_BIT_ERASE], reg_wdata[5:0], serial_mode, is_ee);
    assign addr_nxt = align_addr(cmd_nxt, tgt_r);
    assign done    = (state_r == FPS_ST_RUN) && (cnt_r == '0);

    // Duration; an EEPROM write without skip-preerase erases first
    always_comb
    begin
        dur_nxt = FPS_CNT_W'(ERASE_CYCLES);
        if (cmd_nxt == FPS_CMD_NONE)
            dur_nxt = '0;
        else if (cmd_nxt == FPS_CMD_WRITE)
            dur_nxt = FPS_CNT_W'(WRITE_CYCLES);
        else if (cmd_nxt == FPS_CMD_EEWR)
            dur_nxt = skip_r ? FPS_CNT_W'(WRITE_CYCLES)
                             : FPS_CNT_W'(WRITE_CYCLES + ERASE_CYCLES);
    end

    // Key sequence: 55h then AAh opens one following register write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            key1_r   <= 1'b0;
            unlock_r <= 1'b0;
        end
        else if (wr_key)
        begin
            key1_r   <= (reg_wdata[7:0] == FPS_KEY_FIRST);
            unlock_r <= key1_r && (reg_wdata[7:0] == FPS_KEY_SECOND);
        end
        else if (reg_wr)
        begin
            key1_r   <= 1'b0;
            unlock_r <= 1'b0;  // Any other write closes the window
        end
    end

    // Sequencer state and self-timed counter
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= FPS_ST_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            unique case (state_r)
                FPS_ST_IDLE:
                begin
                    if (launch)
                    begin
                        state_r <= FPS_ST_RUN;
                        cnt_r   <= dur_nxt;
                    end
                end
                FPS_ST_RUN:
                begin
                    if (done || abort_req)
                        state_r <= FPS_ST_IDLE;
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
            endcase
        end
    end

    // Control register; start bit only settable, cleared by hardware
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_r <= FPS_CTRL_RESET[FPS_BIT_START];
            en_r    <= FPS_CTRL_RESET[FPS_BIT_EN];
            skip_r  <= FPS_CTRL_RESET[FPS_BIT_SKIP];
            erase_r <= FPS_CTRL_RESET[FPS_BIT_ERASE];
            op_r    <= FPS_CTRL_RESET[5:0];
        end
        else
        begin
            if (launch)
                start_r <= 1'b1;
            else if (done || abort_req)
                start_r <= 1'b0;
            if (wr_ctrl && state_r == FPS_ST_IDLE)
            begin
                en_r    <= reg_wdata[FPS_BIT_EN];
                skip_r  <= reg_wdata[FPS_BIT_SKIP];
                erase_r <= reg_wdata[FPS_BIT_ERASE];
                op_r    <= reg_wdata[5:0];
            end
        end
    end

    // Error flag: hardware set wins over a software clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            err_r <= FPS_CTRL_RESET[FPS_BIT_ERR];
        else if (refuse || (state_r == FPS_ST_RUN && abort_req))
            err_r <= 1'b1;
        else if (launch)
            err_r <= 1'b0;
        else if (wr_ctrl)
            err_r <= reg_wdata[FPS_BIT_ERR];
    end

    // Page register and target captured from the last table write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            page_r <= '0;
            tgt_r  <= '0;
        end
        else
        begin
            if (wr_page)
                page_r <= reg_wdata[7:0];
            if (tbl_wr && state_r == FPS_ST_IDLE)
                tgt_r <= {page_r, tbl_offset};
        end
    end

    // Table writes go to latches only; refused while a cycle runs
    assign lif.wr_lo   = tbl_wr && !tbl_hi && state_r == FPS_ST_IDLE;
    assign lif.wr_hi   = tbl_wr && tbl_hi && state_r == FPS_ST_IDLE;
    assign lif.wr_idx  = tbl_offset[FPS_IDX_W:1];
    assign lif.wr_data = tbl_data;
    assign lif.rd_idx  = arr_rd_idx;

    // Array command, abort pulse and core stall
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arr_start_r <= 1'b0;
            arr_cmd_r   <= FPS_CMD_NONE;
            arr_addr_r  <= '0;
            arr_abort_r <= 1'b0;
            stall_r     <= 1'b0;
        end
        else
        begin
            arr_start_r <= launch && (cmd_nxt != FPS_CMD_NONE);
            arr_abort_r <= (state_r == FPS_ST_RUN) && abort_req && !done;
            if (launch)
            begin
                arr_cmd_r  <= cmd_nxt;
                arr_addr_r <= addr_nxt;
            end
            // EEPROM work runs in the background; program memory halts the core
            if (launch)
                stall_r <= (cmd_nxt != FPS_CMD_NONE) && (cmd_nxt != FPS_CMD_EE)
                           && (cmd_nxt != FPS_CMD_EEWR);
            else if (done || abort_req)
                stall_r <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; key reads as zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                FPS_OFS_CTRL: rdata_r <= {start_r, en_r, err_r, skip_r, 5'h00,
                                          erase_r, op_r};
                FPS_OFS_PAGE: rdata_r <= {8'h00, page_r};
                default:      rdata_r <= 16'h0000;
            endcase
        end
        else
            rdata_r <= 16'h0000;
    end

    assign reg_rdata   = rdata_r;
    assign arr_rd_data = lif.rd_data;
    assign arr_start   = arr_start_r;
    assign arr_cmd     = arr_cmd_r;
    assign arr_addr    = arr_addr_r;
    assign arr_abort   = arr_abort_r;
    assign cpu_stall   = stall_r;
endmodule : fps_sequencer
`default_nettype wire

/* File: test/fps_sequencer_sva.sv */
// Port checker for the flash sequencer.
// Assumes one clock domain and the cycle counts handed down by the bind.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_sva
    import fps_pkg::*;
#(
    parameter int ERASE_CYCLES = 20,
    parameter int WRITE_CYCLES = 20
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [15:0]             reg_rdata,
    input  wire logic                    serial_mode,
    input  wire logic                    abort_req,
    input  wire logic                    arr_start,
    input  wire fps_pkg::fps_cmd_t       arr_cmd,
    input  wire logic [FPS_ADDR_W-1:0]   arr_addr,
    input  wire logic                    arr_abort,
    input  wire logic                    cpu_stall
);
    logic [1:0]  key_r;
    logic [15:0] scnt_r;
    logic        ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr == FPS_OFS_CTRL;
    // Unlock progress on the bus
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            key_r <= 2'h0;
        else if (reg_wr)
            key_r <= (reg_addr != FPS_OFS_KEY) ? 2'h0 :
                     (reg_wdata[7:0] == FPS_KEY_FIRST) ? 2'h1 :
                     (reg_wdata[7:0] == FPS_KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
    // Stall length counter; too long to unroll
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            scnt_r <= 16'h0;
        else
            scnt_r <= cpu_stall ? scnt_r + 16'h1 : 16'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_KEY_BEFORE_START: assert property (arr_start |-> $past(key_r) == 2'h2)
        else $error("launch without unlock");
    AST_START_NEEDS_EN: assert property (arr_start |->
        $past(ctrl_wr && reg_wdata[FPS_BIT_START] && reg_wdata[FPS_BIT_EN]))
        else $error("launch without start and enable");
    AST_EN_CLEAR_REFUSED: assert property (ctrl_wr && !reg_wdata[FPS_BIT_EN] |=> !arr_start)
        else $error("launch with enable clear");
    AST_PROG_UNDEF_NOP: assert property (ctrl_wr && !reg_wdata[FPS_BIT_ERASE]
        && reg_wdata[5:2] != FPS_OPH_WRITE |=> !arr_start)
        else $error("undefined program code launched");
    AST_SERIAL_ONLY: assert property (arr_start && arr_cmd inside {FPS_CMD_BOOT, FPS_CMD_ALL}
        |-> $past(serial_mode))
        else $error("boot or full erase outside serial mode");
    AST_ROW_ALIGN: assert property (arr_start && arr_cmd == FPS_CMD_ERASE4
        |-> (arr_addr & ~FPS_MASK_4ROW) == 24'h0)
        else $error("four-row erase target not aligned");
    AST_STALL_WITH_START: assert property ($rose(cpu_stall) |-> arr_start)
        else $error("stall without launch");
    AST_STALL_LEN: assert property ($fell(cpu_stall) && !arr_abort |->
        scnt_r == ERASE_CYCLES + 1 || scnt_r == WRITE_CYCLES + 1)
        else $error("stall length wrong");
    AST_KEY_READS_ZERO: assert property (reg_rd && reg_addr == FPS_OFS_KEY
        |=> reg_rdata == 16'h0)
        else $error("key register readable");
    AST_GAP_READS_ZERO: assert property (reg_rd |=> reg_rdata[11:7] == 5'h0)
        else $error("unimplemented bits nonzero");
    AST_ABORT_CAUSE: assert property ($rose(arr_abort) |-> $past(abort_req) || $past(abort_req, 2))
        else $error("abort without request");
endmodule : fps_sequencer_sva
bind fps_sequencer fps_sequencer_sva #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
    i_sva (.*);
`default_nettype wire

/* File: test/fps_core_model.sv */
// Processor core model: register writes and reads, table writes, launches.
// Assumes the register port timing of the sequencer; waits out a stall only in the launch task.
`timescale 1ns/1ps
`default_nettype none
module fps_core_model
    import fps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        cpu_stall,
    input  wire logic [15:0] reg_rdata,
    output var  logic [3:0]  reg_addr,
    output var  logic [15:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic        tbl_wr,
    output var  logic        tbl_hi,
    output var  logic [15:0] tbl_offset,
    output var  logic [15:0] tbl_data
);
    // Bus quiet at time zero
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {tbl_wr, tbl_hi, tbl_offset, tbl_data} = '0;
    end
    // One write; data inverted on release
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // One read; data taken in the cycle after the strobe only
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // One table write into a holding latch lane
    task automatic tw(input logic hi, input logic [15:0] off, input logic [15:0] d);
        @(posedge clk);
        tbl_hi     <= hi;
        tbl_offset <= off;
        tbl_data   <= d;
        tbl_wr     <= 1'b1;
        @(posedge clk);
        tbl_wr     <= 1'b0;
        tbl_data   <= ~d;
    endtask : tw
    // Set up, unlock, start, two idle slots, then sit out the stall
    task automatic launch(input logic [15:0] v);
        wr(FPS_OFS_CTRL, v);
        wr(FPS_OFS_KEY, {8'h00, FPS_KEY_FIRST});
        wr(FPS_OFS_KEY, {8'h00, FPS_KEY_SECOND});
        wr(FPS_OFS_CTRL, v | 16'h8000);
        repeat (2) @(posedge clk);
        #1;
        for (int k = 0; k < 1000 && cpu_stall; k++)
            @(posedge clk);
    endtask : launch
endmodule : fps_core_model
`default_nettype wire

/* File: test/fps_sequencer_test.sv */
// Self-checking bench for the flash sequencer with a core model.
// Assumes shortened cycle counts of 20 for erase and write.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_test;
    import fps_pkg::*;
    logic clk, rst_b, reg_wr, reg_rd, tbl_wr, tbl_hi, serial_mode, abort_req;
    logic arr_start, arr_abort, cpu_stall;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, tbl_offset, tbl_data, w;
    logic [4:0]  arr_rd_idx;
    logic [23:0] arr_rd_data, arr_addr, s_addr;
    fps_cmd_t    arr_cmd, s_cmd;
    logic        stall_seen = 1'b0, abort_seen = 1'b0;
    int          n_start = 0;
    int          n_fail = 0;
    int          comparisons = 0;
    logic [15:0] ops [10] = '{16'h4058, 16'h4059, 16'h405a, 16'h4054, 16'h4050,
                              16'h404c, 16'h4004, 16'h5004, 16'h4068, 16'h4064};
    fps_cmd_t    cmds [10] = '{FPS_CMD_ERASE1, FPS_CMD_ERASE2, FPS_CMD_ERASE4, FPS_CMD_CFG,
                               FPS_CMD_EE, FPS_CMD_GEN, FPS_CMD_WRITE, FPS_CMD_WRITE,
                               FPS_CMD_BOOT, FPS_CMD_ALL};
    logic [23:0] msk [10] = '{FPS_MASK_1ROW, FPS_MASK_2ROW, FPS_MASK_4ROW, 24'h0, 24'h0,
                              24'h0, FPS_MASK_1ROW, FPS_MASK_1ROW, 24'h0, 24'h0};
    logic [15:0] bad [3] = '{16'h4068, 16'h407f, 16'h4008};
    fps_sequencer #(.ERASE_CYCLES(20), .WRITE_CYCLES(20)) i_dut (.*);
    fps_core_model i_core (.*);
    // Array-side monitor
    always @(posedge clk)
    begin
        if (arr_start)
        begin
            n_start++;
            s_cmd  = arr_cmd;
            s_addr = arr_addr;
        end
        stall_seen |= cpu_stall;
        abort_seen |= arr_abort;
    end
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Poll until start drops; bounded
    task automatic wait_done();
        for (int k = 0; k < 200; k++)
        begin
            i_core.rd(FPS_OFS_CTRL, w);
            if (w[FPS_BIT_START] === 1'b0)
                break;
        end
    endtask : wait_done
    task automatic t_reset();
        i_core.rd(FPS_OFS_CTRL, w);
        chk("ctrl_reset", FPS_CTRL_RESET, w);
        i_core.rd(FPS_OFS_KEY, w);
        chk("key_read", 24'h0, w);
        i_core.wr(4'hf, 16'hffff);
        i_core.rd(4'hf, w);
        chk("unmapped_read", 24'h0, w);
    endtask : t_reset
    // Later latch writes overwrite earlier ones; lanes kept apart
    task automatic t_latch();
        for (int k = 0; k < FPS_ROW_WORDS; k++)
            i_core.tw(1'b0, 16'(2 * k), 16'h1111);
        i_core.tw(1'b0, 16'h0006, 16'hbeef);
        i_core.tw(1'b1, 16'h0006, 16'h00a5);
        @(posedge clk) arr_rd_idx <= 5'h03;
        repeat (2) @(posedge clk);
        #1 chk("latch", 24'ha5beef, arr_rd_data);
    endtask : t_latch
    // Every defined command except the EEPROM row write
    task automatic t_ops();
        @(posedge clk) serial_mode <= 1'b1;
        i_core.wr(FPS_OFS_PAGE, 16'h0001);
        i_core.tw(1'b0, 16'h12f4, 16'h0000);
        for (int i = 0; i < 10; i++)
        begin
            n_start = 0;
            stall_seen = 1'b0;
            i_core.launch(ops[i]);
            wait_done();
            chk("starts", 24'h1, n_start);
            chk("cmd", cmds[i], s_cmd);
            if (msk[i] != 24'h0)
                chk("target", 24'h0112f4 & msk[i], s_addr);
            chk("stall", cmds[i] != FPS_CMD_EE, stall_seen);
            chk("ctrl_done", 24'h0, {w[15], w[13], w[11:7]});
        end
        @(posedge clk) serial_mode <= 1'b0;
    endtask : t_ops
    // Refused starts
    task automatic t_refuse();
        n_start = 0;
        i_core.wr(FPS_OFS_CTRL, 16'hc058);
        i_core.rd(FPS_OFS_CTRL, w);
        chk("no_key", 24'h1, {w[15], w[13]});
        i_core.wr(FPS_OFS_CTRL, 16'h0000);
        i_core.launch(16'h0058);
        i_core.rd(FPS_OFS_CTRL, w);
        chk("en_clear", 24'h1, {w[15], w[13]});
        i_core.wr(FPS_OFS_CTRL, 16'h0000);
        i_core.wr(FPS_OFS_KEY, 16'h0055);
        i_core.wr(FPS_OFS_KEY, 16'h00aa);
        i_core.wr(FPS_OFS_PAGE, 16'h0001);
        i_core.wr(FPS_OFS_CTRL, 16'hc058);
        i_core.rd(FPS_OFS_CTRL, w);
        chk("broken_window", 24'h1, {w[15], w[13]});
        chk("refused_starts", 24'h0, n_start);
    endtask : t_refuse
    // Undefined codes do nothing
    task automatic t_undef();
        n_start = 0;
        for (int i = 0; i < 3; i++)
        begin
            i_core.launch(bad[i]);
            wait_done();
            chk("nop_ctrl", 24'h0, {w[15], w[13]});
        end
        chk("nop_starts", 24'h0, n_start);
    endtask : t_undef
    // Premature termination in mid-erase
    task automatic t_abort();
        abort_seen = 1'b0;
        i_core.wr(FPS_OFS_CTRL, 16'h4058);
        i_core.wr(FPS_OFS_KEY, 16'h0055);
        i_core.wr(FPS_OFS_KEY, 16'h00aa);
        i_core.wr(FPS_OFS_CTRL, 16'hc058);
        repeat (6) @(posedge clk);
        abort_req <= 1'b1;
        @(posedge clk) abort_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("abort_stall", 24'h0, cpu_stall);
        i_core.rd(FPS_OFS_CTRL, w);
        chk("abort_ctrl", 24'h1, {w[15], w[13]});
        chk("abort_seen", 24'h1, abort_seen);
    endtask : t_abort
    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is a few hundred cycles; 200 us means a hang
    initial
    begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        rst_b = 1'b0;
        serial_mode = 1'b0;
        abort_req = 1'b0;
        arr_rd_idx = 5'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_latch();
        t_ops();
        t_refuse();
        t_undef();
        t_abort();
        end_sim();
    end
endmodule : fps_sequencer_test
`default_nettype wire
